// >>> common/ldc_pkg.sv
// constants shared by the led driver configuration store
package ldc_pkg;

	// ==========================================================
	// clock and counter sizing
	localparam int CLK_MHZ = 250;
	localparam int CNT_W = 22;
	localparam int ADDR_W = 6;
	localparam int MEM_BITS = 64;

	// ==========================================================
	// entry keys, sent msb first
	localparam logic [7:0] KEY_FIRST = 8'h29;
	localparam logic [7:0] KEY_SECOND = 8'h09;

	// ==========================================================
	// bit addresses of the six fields (lsb of each field)
	localparam logic [5:0] TRIM_ADDR = 6'h24;
	localparam logic [5:0] GATE_ADDR = 6'h28;
	localparam logic [5:0] BLANK_ADDR = 6'h32;
	localparam logic [5:0] SS_ADDR = 6'h34;
	localparam logic [5:0] OSC_ADDR = 6'h37;
	localparam logic [5:0] SLOPE_ADDR = 6'h38;
	// implemented locations; everything else is reserved
	localparam logic [63:0] CFG_MASK = 64'h0ffc_0ff0_0000_0000;
	// factory values: trim 0101, gate 0011, slope 0110, rest zero
	localparam logic [63:0] CFG_RESET = 64'h0600_0350_0000_0000;

	// ==========================================================
	// command byte layout: bit 7 selects write, bits 5..0 address
	localparam int CMD_WR_BIT = 7;
	localparam logic [2:0] SS_OFF_CODE = 3'h7;

	// ==========================================================
	// times in their own units and derived cycle counts
	localparam int PULSE_US = 10;
	localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
	localparam int BIT1_MAX_US = 15;
	localparam int BIT1_MAX_CYC = BIT1_MAX_US * CLK_MHZ;
	localparam int BIT0_MIN_US = 60;
	localparam int BIT0_MIN_CYC = BIT0_MIN_US * CLK_MHZ;
	localparam int KEY_WIN_MS = 8;
	localparam int KEY_WIN_CYC = KEY_WIN_MS * 1000 * CLK_MHZ;
	localparam int FAULT_RETRY_MODE_MS = 8;
	localparam int FAULT_RETRY_MODE_CYC = FAULT_RETRY_MODE_MS * 1000 * CLK_MHZ;
	localparam int INT_OSC_KHZ = 125;
	localparam int INT_OSC_CYC = CLK_MHZ * 1000 / INT_OSC_KHZ;
	localparam int BLANK0_NS = 150;
	localparam int BLANK1_NS = 125;
	localparam int BLANK2_NS = 100;
	localparam int BLANK3_NS = 75;
	localparam int BLANK0_CYC = (BLANK0_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK1_CYC = (BLANK1_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK2_CYC = (BLANK2_NS * CLK_MHZ + 999) / 1000;
	localparam int BLANK3_CYC = (BLANK3_NS * CLK_MHZ + 999) / 1000;
	localparam int SS0_US = 4096;
	localparam int SS1_US = 2048;
	localparam int SS2_US = 1860;
	localparam int SS3_US = 1024;
	localparam int SS4_US = 768;
	localparam int SS5_US = 512;
	localparam int SS6_US = 256;
	localparam int SS0_CYC = SS0_US * CLK_MHZ;
	localparam int SS1_CYC = SS1_US * CLK_MHZ;
	localparam int SS2_CYC = SS2_US * CLK_MHZ;
	localparam int SS3_CYC = SS3_US * CLK_MHZ;
	localparam int SS4_CYC = SS4_US * CLK_MHZ;
	localparam int SS5_CYC = SS5_US * CLK_MHZ;
	localparam int SS6_CYC = SS6_US * CLK_MHZ;

	// ==========================================================
	// state types
	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_PULSE = 3'b001,
		SER_KEYS = 3'b010,
		SER_PROG = 3'b011,
		SER_LOCK = 3'b100
	} ldc_ser_t;

	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_WDATA = 2'b01,
		PH_RSLOT = 2'b10
	} ldc_ph_t;

	typedef enum logic [2:0] {
		P_OFF = 3'b000,
		P_SOFT = 3'b001,
		P_RUN = 3'b010,
		P_OVP = 3'b011,
		P_FAULT_RETRY_MODE = 3'b100
	} ldc_pwr_t;

endpackage

// >>> src/ldc_cfg_mem.sv
// bit-addressed configuration store with registered read port
`timescale 1ns/1ps
`default_nettype none
module ldc_cfg_mem (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// write port
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic wr_bit,
	// read port
	input wire logic [5:0] rd_addr,
	output logic rd_bit,
	// whole image for the control logic
	output logic [63:0] cfg_bits
);
	logic [63:0] cfg_nxt;
	logic rd_nxt;

	// ==========================================================
	// storage: reserved locations never change and read as zero
	genvar gi;
	generate
		for (gi = 0; gi < ldc_pkg::MEM_BITS; gi++) begin : g_bit
			always_comb begin
				cfg_nxt[gi] = cfg_bits[gi];
				if (ldc_pkg::CFG_MASK[gi] && wr_en &&
				    wr_addr == 6'(gi)) begin
					cfg_nxt[gi] = wr_bit;
				end
			end
		end
	endgenerate

	always_comb begin
		rd_nxt = cfg_bits[rd_addr] & ldc_pkg::CFG_MASK[rd_addr];
	end

	// reset stands for the factory image, not for a power cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_bits <= ldc_pkg::CFG_RESET;
			rd_bit <= 1'b0;
		end else if (ce) begin
			cfg_bits <= cfg_nxt;
			rd_bit <= rd_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> src/ldc_led_driver_cfg.sv
// led driver configuration store, single-wire slave and fault control
// Summary of operation
// - one low pulse on pin at enable
// - second key counts only after first
// - keys are 29h then 09h, msb first
// - window over: no access until power cycle
// - after window pin low only on faults
// - bits stored, accessed over single-wire slave
// - one bit per address, others reserved
// - trim code bits 24h-27h, 6.66mV steps
// - trim code factory default gives 133mV
// - gate code 28h-2Bh, default 0011
// - blanking code 32h-33h, 150 to 75ns
// - sense ignored during blanking each cycle
// - soft-start code 34h-36h, 111 disables
// - soft-start needs enable and supply good
// - osc select bit picks internal 125kHz
// - slope code per clock cycle with rt
// - slope code per microsecond otherwise
// - overvoltage stops all switching
// - overvoltage clear restarts soft-start
// - thermal off above 165C, on below 145C
`timescale 1ns/1ps
`default_nettype none
module ldc_led_driver_cfg #(
	parameter int BIT0_MIN_CYC = ldc_pkg::BIT0_MIN_CYC,
	parameter int KEY_WIN_CYC = ldc_pkg::KEY_WIN_CYC,
	parameter int FAULT_RETRY_MODE_CYC = ldc_pkg::FAULT_RETRY_MODE_CYC,
	parameter int SS0_CYC = ldc_pkg::SS0_CYC,
	parameter int SS1_CYC = ldc_pkg::SS1_CYC,
	parameter int SS2_CYC = ldc_pkg::SS2_CYC,
	parameter int SS3_CYC = ldc_pkg::SS3_CYC,
	parameter int SS4_CYC = ldc_pkg::SS4_CYC,
	parameter int SS5_CYC = ldc_pkg::SS5_CYC,
	parameter int SS6_CYC = ldc_pkg::SS6_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// fault / programming pin, open drain
	input wire logic fault_i,
	output logic fault_o,
	output logic fault_oe_n,
	// supervisors and comparators
	input wire logic uv_enable_ok,
	input wire logic vcc_ok,
	input wire logic ov_cmp,
	input wire logic current_limit_comparator_cmp,
	input wire logic fault_retry_mode_cmp,
	input wire logic temp_hot,
	input wire logic temp_cool,
	// oscillator sources
	input wire logic ext_cycle_start,
	input wire logic ext_sync_present,
	input wire logic rt_osc_running,
	// configuration outputs
	output logic [3:0] current_trim_code,
	output logic [3:0] gate_supply_code,
	output logic internal_osc_select,
	output logic [3:0] slope_code,
	output logic slope_per_us,
	// converter control
	output logic cycle_start,
	output logic cs_blank,
	output logic oc_trip,
	output logic pwm_enable,
	output logic softstart_active,
	output logic thermal_off,
	output logic prog_mode
);
	// ==========================================================
	// declarations
	ldc_pkg::ldc_ser_t ser_r, ser_nxt;
	ldc_pkg::ldc_ph_t ph_r, ph_nxt;
	ldc_pkg::ldc_pwr_t pwr_r, pwr_nxt;
	logic [ldc_pkg::CNT_W-1:0] tmr_r, tmr_nxt, low_r, low_nxt;
	logic [ldc_pkg::CNT_W-1:0] hold_r, hold_nxt, pcnt_r, pcnt_nxt;
	logic [ldc_pkg::CNT_W-1:0] ss_len;
	logic [7:0] shift_r, shift_nxt, cmd_r, cmd_nxt, byte_in;
	logic [2:0] nbits_r, nbits_nxt;
	logic key1_r, key1_nxt, busy_r, busy_nxt;
	logic line_prev_r, en_prev_r, drive_nxt, prog_nxt;
	logic bit_ok, bit_val, wr_en, rd_bit, line_rise, line_fall;
	logic [63:0] cfg;
	logic [2:0] ss_code;
	logic [1:0] blank_code;
	logic [11:0] osc_r, osc_nxt;
	logic [5:0] blank_r, blank_nxt, blank_len;
	logic cyc_nxt, blank_out_nxt, oc_nxt, hic_ev, run_ok, therm_nxt;
	logic start_ss;

	assign ss_code = cfg[ldc_pkg::SS_ADDR +: 3];
	assign blank_code = cfg[ldc_pkg::BLANK_ADDR +: 2];

	// ==========================================================
	// configuration store
	ldc_cfg_mem u_mem (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.wr_en(wr_en),
		.wr_addr(cmd_r[5:0]),
		.wr_bit(bit_val),
		.rd_addr(cmd_r[5:0]),
		.rd_bit(rd_bit),
		.cfg_bits(cfg)
	);

	// ==========================================================
	// single-wire slave and programming window
	always_comb begin
		ser_nxt = ser_r;
		ph_nxt = ph_r;
		tmr_nxt = tmr_r;
		low_nxt = low_r;
		hold_nxt = hold_r;
		shift_nxt = shift_r;
		cmd_nxt = cmd_r;
		nbits_nxt = nbits_r;
		key1_nxt = key1_r;
		busy_nxt = busy_r;
		drive_nxt = 1'b0;
		wr_en = 1'b0;
		bit_ok = 1'b0;
		bit_val = 1'b0;
		line_fall = line_prev_r & ~fault_i;
		line_rise = ~line_prev_r & fault_i;
		// a slot is classified by its low time when the line releases;
		// our own window pulse must not be taken for a host slot
		if (!fault_i && !busy_r && fault_oe_n && low_r != '1) begin
			low_nxt = low_r + 1'b1;
		end
		if (line_rise) begin
			low_nxt = '0;
			if (!busy_r && low_r != '0 &&
			    low_r <= ldc_pkg::CNT_W'(ldc_pkg::BIT1_MAX_CYC)) begin
				bit_ok = 1'b1;
				bit_val = 1'b1;
			end else if (!busy_r &&
			             low_r >= ldc_pkg::CNT_W'(BIT0_MIN_CYC)) begin
				bit_ok = 1'b1;
			end
			if (hold_r == '0) begin
				busy_nxt = 1'b0;
			end
		end
		byte_in = {shift_r[6:0], bit_val};
		// device-driven zero of a read slot
		if (hold_r != '0) begin
			hold_nxt = hold_r - 1'b1;
			drive_nxt = (hold_r != 1);
		end
		case (ser_r)
		ldc_pkg::SER_IDLE: begin
			if (uv_enable_ok && !en_prev_r) begin
				ser_nxt = ldc_pkg::SER_PULSE;
				tmr_nxt = '0;
			end
		end
		ldc_pkg::SER_PULSE: begin
			drive_nxt = (tmr_r != ldc_pkg::CNT_W'(ldc_pkg::PULSE_CYC - 1));
			tmr_nxt = tmr_r + 1'b1;
			if (tmr_r == ldc_pkg::CNT_W'(ldc_pkg::PULSE_CYC - 1)) begin
				ser_nxt = ldc_pkg::SER_KEYS;
				tmr_nxt = '0;
				nbits_nxt = '0;
				key1_nxt = 1'b0;
			end
		end
		ldc_pkg::SER_KEYS: begin
			tmr_nxt = tmr_r + 1'b1;
			if (tmr_r == ldc_pkg::CNT_W'(KEY_WIN_CYC - 1) ||
			    !uv_enable_ok) begin
				ser_nxt = ldc_pkg::SER_LOCK;
			end else if (bit_ok) begin
				shift_nxt = byte_in;
				nbits_nxt = nbits_r + 1'b1;
				if (nbits_r == 3'h7) begin
					if (key1_r && byte_in == ldc_pkg::KEY_SECOND) begin
						ser_nxt = ldc_pkg::SER_PROG;
						ph_nxt = ldc_pkg::PH_CMD;
					end else begin
						key1_nxt = (byte_in == ldc_pkg::KEY_FIRST);
					end
				end
			end
		end
		ldc_pkg::SER_PROG: begin
			if (!uv_enable_ok) begin
				ser_nxt = ldc_pkg::SER_LOCK;
			end else begin
				case (ph_r)
				ldc_pkg::PH_CMD: begin
					if (bit_ok) begin
						shift_nxt = byte_in;
						nbits_nxt = nbits_r + 1'b1;
						if (nbits_r == 3'h7) begin
							cmd_nxt = byte_in;
							ph_nxt = byte_in[ldc_pkg::CMD_WR_BIT] ?
							         ldc_pkg::PH_WDATA : ldc_pkg::PH_RSLOT;
						end
					end
				end
				ldc_pkg::PH_WDATA: begin
					if (bit_ok) begin
						wr_en = 1'b1;
						ph_nxt = ldc_pkg::PH_CMD;
					end
				end
				ldc_pkg::PH_RSLOT: begin
					if (line_fall) begin
						busy_nxt = 1'b1;
						ph_nxt = ldc_pkg::PH_CMD;
						if (!rd_bit) begin
							hold_nxt = ldc_pkg::CNT_W'(BIT0_MIN_CYC);
							drive_nxt = 1'b1;
						end
					end
				end
				default: ph_nxt = ldc_pkg::PH_CMD;
				endcase
			end
		end
		ldc_pkg::SER_LOCK: begin
			drive_nxt = ov_cmp | oc_trip | ~uv_enable_ok |
			            (pwr_r == ldc_pkg::P_FAULT_RETRY_MODE);
		end
		default: ser_nxt = ldc_pkg::SER_IDLE;
		endcase
		prog_nxt = (ser_nxt == ldc_pkg::SER_PROG);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ser_r <= ldc_pkg::SER_IDLE;
			ph_r <= ldc_pkg::PH_CMD;
			tmr_r <= '0;
			low_r <= '0;
			hold_r <= '0;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			nbits_r <= 3'h0;
			key1_r <= 1'b0;
			busy_r <= 1'b0;
			line_prev_r <= 1'b1;
			en_prev_r <= 1'b0;
			fault_oe_n <= 1'b1;
			fault_o <= 1'b0;
			prog_mode <= 1'b0;
		end else if (ce) begin
			ser_r <= ser_nxt;
			ph_r <= ph_nxt;
			tmr_r <= tmr_nxt;
			low_r <= low_nxt;
			hold_r <= hold_nxt;
			shift_r <= shift_nxt;
			cmd_r <= cmd_nxt;
			nbits_r <= nbits_nxt;
			key1_r <= key1_nxt;
			busy_r <= busy_nxt;
			line_prev_r <= fault_i;
			en_prev_r <= uv_enable_ok;
			fault_oe_n <= ~drive_nxt;
			fault_o <= 1'b0;
			prog_mode <= prog_nxt;
		end
	end

	// ==========================================================
	// switching cycle, blanking, protection and soft-start
	always_comb begin
		case (blank_code)
		2'b00: blank_len = 6'(ldc_pkg::BLANK0_CYC);
		2'b01: blank_len = 6'(ldc_pkg::BLANK1_CYC);
		2'b10: blank_len = 6'(ldc_pkg::BLANK2_CYC);
		default: blank_len = 6'(ldc_pkg::BLANK3_CYC);
		endcase
		case (ss_code)
		3'h0: ss_len = ldc_pkg::CNT_W'(SS0_CYC);
		3'h1: ss_len = ldc_pkg::CNT_W'(SS1_CYC);
		3'h2: ss_len = ldc_pkg::CNT_W'(SS2_CYC);
		3'h3: ss_len = ldc_pkg::CNT_W'(SS3_CYC);
		3'h4: ss_len = ldc_pkg::CNT_W'(SS4_CYC);
		3'h5: ss_len = ldc_pkg::CNT_W'(SS5_CYC);
		default: ss_len = ldc_pkg::CNT_W'(SS6_CYC);
		endcase
		// free-running internal oscillator; only used when selected
		osc_nxt = (osc_r == 12'(ldc_pkg::INT_OSC_CYC - 1)) ? 12'h000 :
		          osc_r + 12'h001;
		cyc_nxt = cfg[ldc_pkg::OSC_ADDR] ? (osc_r == 12'h000) :
		          ext_cycle_start;
		blank_nxt = cycle_start ? blank_len :
		            (blank_r != 6'h00 ? blank_r - 6'h01 : 6'h00);
		blank_out_nxt = (blank_nxt != 6'h00);
		oc_nxt = current_limit_comparator_cmp & ~cs_blank & pwm_enable;
		hic_ev = fault_retry_mode_cmp & ~cs_blank & pwm_enable;
		therm_nxt = temp_hot | (thermal_off & ~temp_cool);
		run_ok = uv_enable_ok & vcc_ok & ~thermal_off;
		start_ss = 1'b0;
		pwr_nxt = pwr_r;
		pcnt_nxt = pcnt_r + 1'b1;
		case (pwr_r)
		ldc_pkg::P_OFF: start_ss = run_ok & ~ov_cmp;
		ldc_pkg::P_SOFT: begin
			if (pcnt_r >= ss_len - 1'b1) begin
				pwr_nxt = ldc_pkg::P_RUN;
			end
		end
		ldc_pkg::P_RUN: pwr_nxt = ldc_pkg::P_RUN;
		ldc_pkg::P_OVP: start_ss = ~ov_cmp;
		ldc_pkg::P_FAULT_RETRY_MODE: begin
			start_ss = (pcnt_r == ldc_pkg::CNT_W'(FAULT_RETRY_MODE_CYC - 1));
		end
		default: pwr_nxt = ldc_pkg::P_OFF;
		endcase
		if (start_ss) begin
			pcnt_nxt = '0;
			pwr_nxt = (ss_code == ldc_pkg::SS_OFF_CODE) ?
			          ldc_pkg::P_RUN : ldc_pkg::P_SOFT;
		end
		if ((pwr_r == ldc_pkg::P_SOFT || pwr_r == ldc_pkg::P_RUN) &&
		    hic_ev) begin
			pwr_nxt = ldc_pkg::P_FAULT_RETRY_MODE;
			pcnt_nxt = '0;
		end
		if (pwr_r != ldc_pkg::P_OFF && ov_cmp) begin
			pwr_nxt = ldc_pkg::P_OVP;
		end
		if (!run_ok) begin
			pwr_nxt = ldc_pkg::P_OFF;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_r <= ldc_pkg::P_OFF;
			pcnt_r <= '0;
			osc_r <= 12'h000;
			blank_r <= 6'h00;
			cycle_start <= 1'b0;
			cs_blank <= 1'b0;
			oc_trip <= 1'b0;
			thermal_off <= 1'b0;
			pwm_enable <= 1'b0;
			softstart_active <= 1'b0;
		end else if (ce) begin
			pwr_r <= pwr_nxt;
			pcnt_r <= pcnt_nxt;
			osc_r <= osc_nxt;
			blank_r <= blank_nxt;
			cycle_start <= cyc_nxt;
			cs_blank <= blank_out_nxt;
			oc_trip <= oc_nxt;
			thermal_off <= therm_nxt;
			pwm_enable <= (pwr_nxt == ldc_pkg::P_SOFT) |
			              (pwr_nxt == ldc_pkg::P_RUN);
			softstart_active <= (pwr_nxt == ldc_pkg::P_SOFT);
		end
	end

	// ==========================================================
	// configuration fields out of flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			current_trim_code <= ldc_pkg::CFG_RESET[ldc_pkg::TRIM_ADDR +: 4];
			gate_supply_code <= ldc_pkg::CFG_RESET[ldc_pkg::GATE_ADDR +: 4];
			internal_osc_select <= ldc_pkg::CFG_RESET[ldc_pkg::OSC_ADDR];
			slope_code <= ldc_pkg::CFG_RESET[ldc_pkg::SLOPE_ADDR +: 4];
			slope_per_us <= 1'b0;
		end else if (ce) begin
			current_trim_code <= cfg[ldc_pkg::TRIM_ADDR +: 4];
			gate_supply_code <= cfg[ldc_pkg::GATE_ADDR +: 4];
			internal_osc_select <= cfg[ldc_pkg::OSC_ADDR];
			slope_code <= cfg[ldc_pkg::SLOPE_ADDR +: 4];
			slope_per_us <= cfg[ldc_pkg::OSC_ADDR] |
			                ext_sync_present | ~rt_osc_running;
		end
	end
endmodule
`default_nettype wire

// >>> dv/ldc_host_model.sv
// single-wire bus master model pulling the shared fault pin
`timescale 1ns/1ps
`default_nettype none
module ldc_host_model #(
	parameter int BIT0_CYC = 4000
) (
	// clock
	input wire logic clk,
	// host pull-down on the open-drain wire
	output logic host_pull
);
	initial host_pull = 1'b0;
	// ====
	// slots; called just after a falling edge
	task automatic slot(input logic b, input int gap);
		host_pull = 1'b1;
		// short low is a one, long low a zero
		repeat (b ? 1 : BIT0_CYC) @(negedge clk);
		host_pull = 1'b0;
		// line must be seen high between slots
		repeat (2 + gap) @(negedge clk);
	endtask
	task automatic send_byte(input logic [7:0] v, input int gap);
		for (int i = 7; i >= 0; i--) begin
			slot(v[i], gap);
		end
	endtask
endmodule
`default_nettype wire

// >>> dv/ldc_led_driver_cfg_sva.sv
// concurrent checks on the converter control outputs
`timescale 1ns/1ps
`default_nettype none
module ldc_led_driver_cfg_sva (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// supervisors and comparators
	input wire logic uv_enable_ok,
	input wire logic vcc_ok,
	input wire logic ov_cmp,
	input wire logic current_limit_comparator_cmp,
	input wire logic temp_hot,
	input wire logic temp_cool,
	input wire logic ext_sync_present,
	// control outputs
	input wire logic cycle_start,
	input wire logic cs_blank,
	input wire logic oc_trip,
	input wire logic pwm_enable,
	input wire logic softstart_active,
	input wire logic thermal_off,
	input wire logic slope_per_us
);
	default clocking cb @(posedge clk); endclocking
	// a frozen clock enable stretches every cycle count, so skip it
	default disable iff (!resetn || !ce);
	// ====
	// length of the current blanking run
	logic [7:0] blank_cnt_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blank_cnt_r <= 8'h00;
		end else if (ce) begin
			blank_cnt_r <= cs_blank ? blank_cnt_r + 8'h01 : 8'h00;
		end
	end
	sequence s_ov_held;
		ov_cmp [*3];
	endsequence
	sequence s_ov_clear;
		$fell(ov_cmp) && uv_enable_ok && vcc_ok && !thermal_off;
	endsequence
	property p_blank_start;
		cycle_start |=> cs_blank;
	endproperty
	property p_blank_len;
		$fell(cs_blank) |-> blank_cnt_r inside {8'h26, 8'h20, 8'h19, 8'h13};
	endproperty
	property p_oc_mask;
		cs_blank |=> !oc_trip;
	endproperty
	property p_oc_trip;
		current_limit_comparator_cmp && !cs_blank && pwm_enable |=> oc_trip;
	endproperty
	property p_ov_stop;
		s_ov_held |-> !pwm_enable;
	endproperty
	property p_ov_restart;
		s_ov_clear |-> ##[1:4] softstart_active;
	endproperty
	property p_soft_gate;
		$rose(softstart_active) |-> $past(uv_enable_ok) && $past(vcc_ok);
	endproperty
	property p_therm_set;
		temp_hot |=> thermal_off;
	endproperty
	property p_therm_hold;
		thermal_off && !temp_cool |=> thermal_off;
	endproperty
	property p_slope_us;
		ext_sync_present |=> slope_per_us;
	endproperty
	a_blank_start: assert property (p_blank_start)
		else $error("no blanking after cycle start");
	a_blank_len: assert property (p_blank_len)
		else $error("blanking length not a coded value");
	a_oc_mask: assert property (p_oc_mask)
		else $error("current trip while blanked");
	a_oc_trip: assert property (p_oc_trip)
		else $error("unblanked current limit missed");
	a_ov_stop: assert property (p_ov_stop)
		else $error("switching during overvoltage");
	a_ov_restart: assert property (p_ov_restart)
		else $error("no soft start after overvoltage");
	a_soft_gate: assert property (p_soft_gate)
		else $error("soft start without enable and supply");
	a_therm_set: assert property (p_therm_set)
		else $error("hot die not shut down");
	a_therm_hold: assert property (p_therm_hold)
		else $error("thermal flag cleared above low threshold");
	a_slope_us: assert property (p_slope_us)
		else $error("slope not per microsecond with sync");
endmodule
bind ldc_led_driver_cfg ldc_led_driver_cfg_sva i_sva (
	.clk(clk), .resetn(resetn), .ce(ce), .uv_enable_ok(uv_enable_ok),
	.vcc_ok(vcc_ok), .ov_cmp(ov_cmp), .current_limit_comparator_cmp(current_limit_comparator_cmp),
	.temp_hot(temp_hot), .temp_cool(temp_cool),
	.ext_sync_present(ext_sync_present), .cycle_start(cycle_start),
	.cs_blank(cs_blank), .oc_trip(oc_trip), .pwm_enable(pwm_enable),
	.softstart_active(softstart_active), .thermal_off(thermal_off),
	.slope_per_us(slope_per_us)
);
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the led driver configuration store
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int B0 = 4000;
	localparam int SS0 = 70;
	localparam int T_NS = 4;
	logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, fault_retry_mode_cmp = 1'b0;
	logic uv_enable_ok = 1'b0, vcc_ok = 1'b0, ov_cmp = 1'b0;
	logic current_limit_comparator_cmp = 1'b0, temp_hot = 1'b0, temp_cool = 1'b0;
	logic ext_cycle_start = 1'b0, ext_sync_present = 1'b0;
	logic rt_osc_running = 1'b1;
	logic fault_o, fault_oe_n, host_pull, cycle_start, cs_blank, oc_trip;
	logic pwm_enable, softstart_active, thermal_off, prog_mode;
	logic slope_per_us, internal_osc_select;
	logic [3:0] current_trim_code, gate_supply_code, slope_code;
	logic [31:0] rnd = 32'h69a7;
	wire logic fault_i;
	int n_mismatch = 0, n_checks = 0, k, m;
	int mdl[64];
	// pulled-up wire: low while either side pulls
	assign fault_i = ~(~fault_oe_n | host_pull);
	always #2 clk = ~clk;
	ldc_led_driver_cfg #(.BIT0_MIN_CYC(B0), .KEY_WIN_CYC(60000),
		.FAULT_RETRY_MODE_CYC(200), .SS0_CYC(SS0), .SS1_CYC(60), .SS2_CYC(50),
		.SS3_CYC(40), .SS4_CYC(30), .SS5_CYC(20), .SS6_CYC(10)
	) i_ldc_led_driver_cfg (.clk(clk), .resetn(resetn), .ce(ce),
		.fault_i(fault_i), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
		.uv_enable_ok(uv_enable_ok), .vcc_ok(vcc_ok), .ov_cmp(ov_cmp),
		.current_limit_comparator_cmp(current_limit_comparator_cmp), .fault_retry_mode_cmp(fault_retry_mode_cmp), .temp_hot(temp_hot),
		.temp_cool(temp_cool), .ext_cycle_start(ext_cycle_start),
		.ext_sync_present(ext_sync_present),
		.rt_osc_running(rt_osc_running),
		.current_trim_code(current_trim_code),
		.gate_supply_code(gate_supply_code),
		.internal_osc_select(internal_osc_select), .slope_code(slope_code),
		.slope_per_us(slope_per_us), .cycle_start(cycle_start),
		.cs_blank(cs_blank), .oc_trip(oc_trip), .pwm_enable(pwm_enable),
		.softstart_active(softstart_active), .thermal_off(thermal_off),
		.prog_mode(prog_mode));
	ldc_host_model #(.BIT0_CYC(B0)) i_ldc_host_model (.clk(clk),
		.host_pull(host_pull));
	// ====
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic int fld(input int lsb, input int w);
		int r = 0;
		for (int i = 0; i < w; i++) r += mdl[lsb + i] << i;
		return r;
	endfunction
	task automatic put(input int lsb, input int w, input int v);
		for (int i = 0; i < w; i++) mdl[lsb + i] = (v >> i) & 1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tmo(input int i, input int lim, input string nm);
		if (i >= lim) begin
			n_mismatch++;
			$display("MISMATCH %s expected event seen timeout", nm);
			final_report();
		end
	endtask
	task automatic wait_lv(ref logic s, input logic lv, input int lim,
		input string nm);
		int i;
		n_checks++;
		for (i = 0; i < lim && s !== lv; i++) @(negedge clk);
		tmo(i, lim, nm);
	endtask
	task automatic run_len(ref logic s, input logic lv, output int n);
		n = 0;
		while (s === lv && n < 5000) begin
			n++;
			@(negedge clk);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ====
	// main sequence
	initial begin
		for (int i = 0; i < 64; i++) mdl[i] = 0;
		put(6'h24, 4, 4'h5);
		put(6'h28, 4, 4'h3);
		put(6'h38, 4, 4'h6);
		cyc(2);
		resetn = 1'b1;
		cyc(1);
		chk("trim", fld(6'h24, 4), current_trim_code);
		chk("gate", fld(6'h28, 4), gate_supply_code);
		chk("osc", fld(6'h37, 1), internal_osc_select);
		chk("slope", fld(6'h38, 4), slope_code);
		chk("pin idle", 1, fault_oe_n);
		$display("test reset done");
		uv_enable_ok = 1'b1;
		wait_lv(fault_oe_n, 1'b0, 20, "pulse");
		run_len(fault_oe_n, 1'b0, m);
		chk("pulse len", ldc_pkg::PULSE_CYC - 1, m);
		cyc(2);
		rnd = lfsr(rnd);
		i_ldc_host_model.send_byte(8'h29, rnd[1:0]);
		i_ldc_host_model.send_byte(8'h09, rnd[3:2]);
		chk("prog", 1, prog_mode);
		$display("test keys done");
		// write bit 24h with a random value, command bit 7 selects write
		i_ldc_host_model.send_byte(8'ha4, rnd[5:4]);
		i_ldc_host_model.slot(rnd[6], 0);
		put(6'h24, 1, rnd[6]);
		cyc(3);
		chk("trim wr", fld(6'h24, 4), current_trim_code);
		$display("test write done");
		// reserved 3fh: a written one is dropped, bit 6 of a read ignored
		i_ldc_host_model.send_byte(8'hff, 0);
		i_ldc_host_model.slot(1'b1, 0);
		i_ldc_host_model.send_byte(8'h7f, rnd[8:7]);
		i_ldc_host_model.slot(1'b1, 0);
		chk("rsv rd", fld(6'h3f, 1), fault_oe_n);
		wait_lv(fault_oe_n, 1'b1, 5000, "rd end");
		cyc(2);
		$display("test reserved done");
		uv_enable_ok = 1'b0;
		cyc(3);
		chk("prog end", 0, prog_mode);
		chk("uv pin", 0, fault_oe_n);
		uv_enable_ok = 1'b1;
		cyc(3);
		for (k = 0; k < 3000 && fault_oe_n === 1'b1; k++) @(negedge clk);
		chk("no pulse", 3000, k);
		$display("test lock done");
		vcc_ok = 1'b1;
		wait_lv(softstart_active, 1'b1, 10, "soft");
		run_len(softstart_active, 1'b1, m);
		chk("soft len", SS0, m);
		chk("run", 1, pwm_enable);
		for (int t = 0; t < 4; t++) begin
			rnd = lfsr(rnd);
			current_limit_comparator_cmp = rnd[0];
			ext_cycle_start = 1'b1;
			cyc(1);
			ext_cycle_start = 1'b0;
			wait_lv(cs_blank, 1'b1, 5, "blank");
			run_len(cs_blank, 1'b1, m);
			chk("blank len", (150 + T_NS - 1) / T_NS, m);
			cyc(1);
			chk("oc", current_limit_comparator_cmp, oc_trip);
			current_limit_comparator_cmp = 1'b0;
			cyc(3);
		end
		$display("test blank done");
		fault_retry_mode_cmp = 1'b1;
		cyc(1);
		fault_retry_mode_cmp = 1'b0;
		cyc(3);
		chk("fault_retry_mode stop", 0, pwm_enable);
		chk("fault_retry_mode pin", 0, fault_oe_n);
		wait_lv(softstart_active, 1'b1, 300, "fault_retry_mode restart");
		$display("test fault_retry_mode done");
		ov_cmp = 1'b1;
		cyc(4);
		chk("ov stop", 0, pwm_enable);
		chk("ov pin", 0, fault_oe_n);
		ov_cmp = 1'b0;
		wait_lv(softstart_active, 1'b1, 6, "ov restart");
		$display("test ov done");
		ce = 1'b0;
		temp_hot = 1'b1;
		cyc(3);
		chk("frozen", 0, thermal_off);
		ce = 1'b1;
		cyc(4);
		chk("hot", 1, thermal_off);
		chk("hot pwm", 0, pwm_enable);
		temp_hot = 1'b0;
		cyc(3);
		chk("hold", 1, thermal_off);
		temp_cool = 1'b1;
		cyc(3);
		chk("cool", 0, thermal_off);
		$display("test thermal done");
		ext_sync_present = 1'b1;
		cyc(2);
		chk("per us", 1, slope_per_us);
		ext_sync_present = 1'b0;
		rt_osc_running = 1'b0;
		cyc(2);
		chk("rt off", 1, slope_per_us);
		rt_osc_running = 1'b1;
		cyc(2);
		chk("per clk", 0, slope_per_us);
		$display("test slope done");
		final_report();
	end
endmodule
`default_nettype wire
